// file: design/spc_power_reset_control.sv
// Top of the system power and reset control block: registers behind the management slave.
// Assumes strap and package pins are static levels; these pins pass two flip-flops.
`timescale 1ns/1ps
module spc_power_reset_control #(
  parameter int STARTUP_CYCLES = spc_pkg::SPC_STARTUP_CYCLES,
  parameter int RESET_CYCLES = spc_pkg::SPC_RESET_CYCLES
) (
  // system
  input wire logic clk,
  input wire logic rst_n,
  // management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // straps
  input wire logic [4:0] port_address,
  input wire logic powerdown_strap_pin,
  input wire logic [5:0] package_type_pins,
  // controlled resets and enables
  output logic phy_subsystem_reset_n,
  output logic mac_interface_reset_n,
  output logic core_power_enable,
  output logic boot_oscillator_clock_enable,
  output logic diagnostics_clock_gate,
  // status
  output logic system_ready,
  output logic powerdown_state
);

  typedef struct packed {
    logic [1:0] strap_s;
    logic [1:0][4:0] port_s;
    logic [1:0][5:0] pkg_s;
    logic soft_powerdown_request;
    logic force_boot_oscillator;
    logic diagnostics_clock_enable;
    logic group_address_mode_enable;
  } spc_top_s;

  spc_top_s q;
  spc_top_s next_q;
  logic [15:0] reg_addr;
  logic wr_stb;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic phy_start;
  logic mac_start;
  logic phy_busy;
  logic mac_busy;

  // serial management slave, never gated by power-down
  spc_mdio_slave u_mdio ( // RQ3
    .clk(clk),
    .rst_n(rst_n),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .port_address(q.port_s[1]),
    .group_address_mode_enable(q.group_address_mode_enable),
    .reg_addr(reg_addr),
    .wr_stb(wr_stb),
    .wr_data(wr_data),
    .rd_data(rd_data)
  );

  // start-up, power-down and subsystem reset sequencing
  spc_sequencer #(
    .STARTUP_CYCLES(STARTUP_CYCLES),
    .RESET_CYCLES(RESET_CYCLES)
  ) u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .powerdown_request(q.soft_powerdown_request),
    .force_boot_oscillator(q.force_boot_oscillator),
    .diagnostics_clock_enable(q.diagnostics_clock_enable),
    .phy_start(phy_start),
    .mac_start(mac_start),
    .system_ready_flag(system_ready),
    .powerdown_state_flag(powerdown_state),
    .phy_busy(phy_busy),
    .mac_busy(mac_busy),
    .phy_subsystem_reset_n(phy_subsystem_reset_n),
    .mac_interface_reset_n(mac_interface_reset_n),
    .core_power_enable(core_power_enable),
    .boot_oscillator_clock_enable(boot_oscillator_clock_enable),
    .diagnostics_clock_gate(diagnostics_clock_gate)
  );

  // pin synchronisers, register writes, read decode and reset values
  always_comb begin
    next_q = q;
    phy_start = 1'b0;
    mac_start = 1'b0;
    next_q.strap_s = {q.strap_s[0], powerdown_strap_pin};
    next_q.port_s = {q.port_s[0], port_address};
    next_q.pkg_s = {q.pkg_s[0], package_type_pins};
    if (wr_stb) begin
      unique case (reg_addr)
        spc_pkg::SPC_REG_SOFT_PD:
          next_q.soft_powerdown_request = wr_data[spc_pkg::SPC_BIT_CTRL]; // RQ2
        spc_pkg::SPC_REG_PHY_RST:
          phy_start = wr_data[spc_pkg::SPC_BIT_CTRL]; // RQ5
        spc_pkg::SPC_REG_MAC_RST:
          mac_start = wr_data[spc_pkg::SPC_BIT_CTRL]; // RQ6
        spc_pkg::SPC_REG_PMG:
          next_q.force_boot_oscillator = wr_data[spc_pkg::SPC_BIT_CTRL]; // RQ9
        spc_pkg::SPC_REG_DIAG:
          next_q.diagnostics_clock_enable = wr_data[spc_pkg::SPC_BIT_CTRL]; // RQ10
        spc_pkg::SPC_REG_MDIO_CTRL:
          next_q.group_address_mode_enable = wr_data[spc_pkg::SPC_BIT_CTRL]; // RQ12
        default: next_q.group_address_mode_enable = q.group_address_mode_enable;
      endcase
    end
    rd_data = spc_pkg::SPC_RESET_ZERO;
    case (reg_addr)
      spc_pkg::SPC_REG_SOFT_PD:
        rd_data[spc_pkg::SPC_BIT_CTRL] = q.soft_powerdown_request;
      spc_pkg::SPC_REG_PHY_RST:
        rd_data[spc_pkg::SPC_BIT_CTRL] = phy_busy; // RQ5
      spc_pkg::SPC_REG_MAC_RST:
        rd_data[spc_pkg::SPC_BIT_CTRL] = mac_busy; // RQ6
      spc_pkg::SPC_REG_STATUS: begin
        rd_data[spc_pkg::SPC_BIT_PD_FLAG] = powerdown_state; // RQ7
        rd_data[spc_pkg::SPC_BIT_READY] = system_ready; // RQ8
      end
      spc_pkg::SPC_REG_PMG:
        rd_data[spc_pkg::SPC_BIT_CTRL] = q.force_boot_oscillator;
      spc_pkg::SPC_REG_DIAG: begin
        rd_data = spc_pkg::SPC_DIAG_RESET;
        rd_data[spc_pkg::SPC_BIT_CTRL] = q.diagnostics_clock_enable;
      end
      spc_pkg::SPC_REG_PKG:
        rd_data[spc_pkg::SPC_PKG_W-1:0] = q.pkg_s[1]; // RQ11
      spc_pkg::SPC_REG_MDIO_CTRL:
        rd_data[spc_pkg::SPC_BIT_CTRL] = q.group_address_mode_enable;
      default: rd_data = spc_pkg::SPC_RESET_ZERO;
    endcase
    if (!rst_n) begin
      next_q.soft_powerdown_request = q.strap_s[1]; // RQ4
      next_q.force_boot_oscillator = 1'b0;
      next_q.diagnostics_clock_enable = 1'b0;
      next_q.group_address_mode_enable = 1'b0;
      phy_start = 1'b0;
      mac_start = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    q <= next_q;
  end

endmodule : spc_power_reset_control

// file: design/spc_pkg.sv
// Constants, types and helpers shared by the system power and reset control block.
// Assumes a single 40 MHz clock and a synchronous active-low reset held at least 3 edges.
// Behaviour
// (RQ1) all registers answer in management device 0x1e, each 16 bits at its address
// (RQ2) soft power-down bit 0 set puts the device into a low-power state
// (RQ3) management reads and writes keep working while powered down
// (RQ4) power-down bit resets to the level of the power-down strap pin
// (RQ5) writing 1 starts a PHY subsystem reset; bit self-clears when done
// (RQ6) writing 1 starts a MAC interface reset; bit self-clears when done
// (RQ7) status bit 1 reads 1 while in the power-down state, resets to 0
// (RQ8) status bit 0 reads 1 once start-up finished and system is ready
// (RQ9) power management bit 0, reset 0, forces the boot oscillator clock on
// (RQ10) diagnostics clock control bit 0, reset 0, gates the diagnostics clock on
// (RQ11) package register shows a read-only 6-bit package type in bits 5 to 0
// (RQ12) group mode makes writes and address frames to port 31 accepted
// (RQ13) host sets group mode only during multiport init, then clears it
// (RQ14) group mode never answers reads to port 31 unless that is our own port
package spc_pkg;

  // management frame addressing
  localparam logic [4:0] SPC_DEV_ADDR = 5'h1e;
  localparam logic [4:0] SPC_GROUP_PORT = 5'h1f;

  // register addresses inside the device
  localparam logic [15:0] SPC_REG_SOFT_PD = 16'h8812;
  localparam logic [15:0] SPC_REG_PHY_RST = 16'h8814;
  localparam logic [15:0] SPC_REG_MAC_RST = 16'h8815;
  localparam logic [15:0] SPC_REG_STATUS = 16'h8818;
  localparam logic [15:0] SPC_REG_PMG = 16'h8819;
  localparam logic [15:0] SPC_REG_DIAG = 16'h882c;
  localparam logic [15:0] SPC_REG_PKG = 16'h8c22;
  localparam logic [15:0] SPC_REG_MDIO_CTRL = 16'h8c30;

  // field positions and values after reset
  localparam int SPC_BIT_CTRL = 0;
  localparam int SPC_BIT_READY = 0;
  localparam int SPC_BIT_PD_FLAG = 1;
  localparam int SPC_PKG_W = 6;
  localparam logic [15:0] SPC_RESET_ZERO = 16'h0000;
  localparam logic [15:0] SPC_DIAG_RESET = 16'h0002;

  // clause 45 opcodes and frame field lengths
  localparam logic [1:0] SPC_OP_ADDR = 2'h0;
  localparam logic [1:0] SPC_OP_WRITE = 2'h1;
  localparam logic [1:0] SPC_OP_READ_INC = 2'h2;
  localparam logic [1:0] SPC_OP_READ = 2'h3;
  localparam logic [5:0] SPC_PREAMBLE_BITS = 6'h20;
  localparam logic [5:0] SPC_HDR_BITS = 6'h0d;
  localparam logic [5:0] SPC_DATA_BITS = 6'h10;

  // timing of the managed sequences
  localparam int SPC_CLK_NS = 25;
  localparam int SPC_RESET_HOLD_NS = 400;
  localparam int SPC_STARTUP_NS = 10000;
  localparam int SPC_RESET_CYCLES = (SPC_RESET_HOLD_NS + SPC_CLK_NS - 1) / SPC_CLK_NS;
  localparam int SPC_STARTUP_CYCLES = (SPC_STARTUP_NS + SPC_CLK_NS - 1) / SPC_CLK_NS;

  typedef enum logic [1:0] {SPC_PRE, SPC_HDR, SPC_TA, SPC_DAT} spc_mdio_e;
  typedef enum logic [1:0] {SPC_BOOT, SPC_RUN, SPC_PD} spc_seq_e;

  // one-shot counter: reload on a start while idle, else count down to zero
  function automatic logic [15:0] spc_count(input logic start, input logic [15:0] c,
                                            input logic [15:0] load);
    if (c != 16'h0000) begin
      return c - 16'h0001;
    end
    return start ? load : 16'h0000;
  endfunction : spc_count

endpackage : spc_pkg

// file: design/spc_mdio_slave.sv
// Clause 45 serial management slave: frame decode, address pointer, read drive.
// Assumes mdc and mdio_in come from pins; both pass two flip-flops before use.
`timescale 1ns/1ps
module spc_mdio_slave (
  // system
  input wire logic clk,
  input wire logic rst_n,
  // management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // configuration
  input wire logic [4:0] port_address,
  input wire logic group_address_mode_enable,
  // register side
  output logic [15:0] reg_addr,
  output logic wr_stb,
  output logic [15:0] wr_data,
  input wire logic [15:0] rd_data
);

  typedef struct packed {
    logic [2:0] mdc_s;
    logic [1:0] mdio_s;
    spc_pkg::spc_mdio_e ph;
    logic [5:0] cnt;
    logic [15:0] sh;
    logic [1:0] op;
    logic hit;
    logic rd;
    logic [15:0] addr;
    logic oe;
    logic dout;
    logic wr;
  } spc_mdio_s;

  spc_mdio_s q;
  spc_mdio_s next_q;
  logic rise;
  logic fall;
  logic [15:0] nsh;
  logic hit_c;

  // edges from the second and third stage only
  assign rise = q.mdc_s[1] & ~q.mdc_s[2];
  assign fall = ~q.mdc_s[1] & q.mdc_s[2];
  assign nsh = {q.sh[14:0], q.mdio_s[1]};
  // own port, or group port for non-read frames
  assign hit_c = (nsh[4:0] == spc_pkg::SPC_DEV_ADDR) && // RQ1
                 ((nsh[9:5] == port_address) ||
                  (group_address_mode_enable && nsh[9:5] == spc_pkg::SPC_GROUP_PORT &&
                   !nsh[11])); // RQ12 RQ14

  // frame sequencing on sampled clock edges
  always_comb begin
    next_q = q;
    next_q.wr = 1'b0;
    next_q.mdc_s = {q.mdc_s[1:0], mdc};
    next_q.mdio_s = {q.mdio_s[0], mdio_in};
    if (rise) begin
      unique case (q.ph)
        spc_pkg::SPC_PRE: begin
          if (q.mdio_s[1]) begin
            if (q.cnt != spc_pkg::SPC_PREAMBLE_BITS) next_q.cnt = q.cnt + 6'h01;
          end else begin
            if (q.cnt == spc_pkg::SPC_PREAMBLE_BITS) next_q.ph = spc_pkg::SPC_HDR;
            next_q.cnt = 6'h00;
          end
        end
        spc_pkg::SPC_HDR: begin
          next_q.sh = nsh;
          next_q.cnt = q.cnt + 6'h01;
          if (q.cnt == spc_pkg::SPC_HDR_BITS - 6'h01) begin
            next_q.cnt = 6'h00;
            next_q.op = nsh[11:10];
            next_q.hit = hit_c;
            next_q.rd = hit_c & nsh[11];
            next_q.ph = nsh[12] ? spc_pkg::SPC_PRE : spc_pkg::SPC_TA;
          end
        end
        spc_pkg::SPC_TA: begin
          next_q.cnt = q.cnt + 6'h01;
          if (q.cnt == 6'h00) begin
            next_q.oe = q.rd; // second turnaround bit driven low
            next_q.dout = 1'b0;
          end else begin
            next_q.cnt = 6'h00;
            next_q.ph = spc_pkg::SPC_DAT;
            next_q.sh = rd_data;
          end
        end
        spc_pkg::SPC_DAT: begin
          next_q.cnt = q.cnt + 6'h01;
          if (!q.rd) next_q.sh = nsh;
          if (q.cnt == spc_pkg::SPC_DATA_BITS - 6'h01) begin
            next_q.ph = spc_pkg::SPC_PRE;
            next_q.cnt = 6'h00;
            if (q.hit) begin
              unique case (q.op)
                spc_pkg::SPC_OP_ADDR: next_q.addr = nsh;
                spc_pkg::SPC_OP_WRITE: next_q.wr = 1'b1;
                spc_pkg::SPC_OP_READ_INC: next_q.addr = q.addr + 16'h0001;
                spc_pkg::SPC_OP_READ: next_q.addr = q.addr;
              endcase
            end
          end
        end
      endcase
    end
    // read data changes on the falling edge, released after the frame
    if (fall) begin
      if (q.ph == spc_pkg::SPC_DAT && q.rd) begin
        next_q.dout = q.sh[15];
        next_q.sh = {q.sh[14:0], 1'b0};
      end else if (q.ph == spc_pkg::SPC_PRE) begin
        next_q.oe = 1'b0;
      end
    end
    if (!rst_n) begin
      next_q.ph = spc_pkg::SPC_PRE;
      next_q.cnt = 6'h00;
      next_q.sh = 16'h0000;
      next_q.op = spc_pkg::SPC_OP_ADDR;
      next_q.hit = 1'b0;
      next_q.rd = 1'b0;
      next_q.addr = 16'h0000;
      next_q.oe = 1'b0;
      next_q.dout = 1'b0;
      next_q.wr = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    q <= next_q;
  end

  assign mdio_out = q.dout;
  assign mdio_oe = q.oe;
  assign reg_addr = q.addr;
  assign wr_stb = q.wr;
  assign wr_data = q.sh;

endmodule : spc_mdio_slave

// file: design/spc_sequencer.sv
// Start-up, power-down and managed subsystem reset sequencing.
// Assumes requests come from logic on the same clock.
`timescale 1ns/1ps
module spc_sequencer #(
  parameter int STARTUP_CYCLES = spc_pkg::SPC_STARTUP_CYCLES,
  parameter int RESET_CYCLES = spc_pkg::SPC_RESET_CYCLES
) (
  // system
  input wire logic clk,
  input wire logic rst_n,
  // controls
  input wire logic powerdown_request,
  input wire logic force_boot_oscillator,
  input wire logic diagnostics_clock_enable,
  input wire logic phy_start,
  input wire logic mac_start,
  // status
  output logic system_ready_flag,
  output logic powerdown_state_flag,
  output logic phy_busy,
  output logic mac_busy,
  // controlled resets and enables
  output logic phy_subsystem_reset_n,
  output logic mac_interface_reset_n,
  output logic core_power_enable,
  output logic boot_oscillator_clock_enable,
  output logic diagnostics_clock_gate
);

  typedef struct packed {
    spc_pkg::spc_seq_e st;
    logic [15:0] cnt;
    logic [15:0] phy_cnt;
    logic [15:0] mac_cnt;
    logic rdy;
    logic pd;
    logic phy_rn;
    logic mac_rn;
    logic pwr;
    logic osc;
    logic dclk;
  } spc_seq_s;

  spc_seq_s q;
  spc_seq_s next_q;

  // state walk and registered outputs decoded from the next state
  always_comb begin
    next_q = q;
    unique case (q.st)
      spc_pkg::SPC_BOOT: begin
        next_q.cnt = q.cnt + 16'h0001;
        if (powerdown_request) begin
          next_q.st = spc_pkg::SPC_PD; // RQ2
        end else if (q.cnt == 16'(STARTUP_CYCLES - 1)) begin
          next_q.st = spc_pkg::SPC_RUN;
        end
      end
      spc_pkg::SPC_RUN: begin
        if (powerdown_request) next_q.st = spc_pkg::SPC_PD; // RQ2
      end
      spc_pkg::SPC_PD: begin
        if (!powerdown_request) begin
          next_q.st = spc_pkg::SPC_BOOT;
          next_q.cnt = 16'h0000;
        end
      end
      // the spare state code restarts the boot sequence
      default: begin
        next_q.st = spc_pkg::SPC_BOOT;
        next_q.cnt = 16'h0000;
      end
    endcase
    next_q.phy_cnt = spc_pkg::spc_count(phy_start, q.phy_cnt, 16'(RESET_CYCLES)); // RQ5
    next_q.mac_cnt = spc_pkg::spc_count(mac_start, q.mac_cnt, 16'(RESET_CYCLES)); // RQ6
    next_q.rdy = next_q.st == spc_pkg::SPC_RUN; // RQ8
    next_q.pd = next_q.st == spc_pkg::SPC_PD; // RQ7
    next_q.phy_rn = next_q.rdy && next_q.phy_cnt == 16'h0000;
    next_q.mac_rn = next_q.rdy && next_q.mac_cnt == 16'h0000;
    next_q.pwr = !next_q.pd; // RQ2
    next_q.osc = force_boot_oscillator | !next_q.pd; // RQ9
    next_q.dclk = diagnostics_clock_enable & !next_q.pd; // RQ10
    if (!rst_n) begin
      next_q.st = spc_pkg::SPC_BOOT;
      next_q.cnt = 16'h0000;
      next_q.phy_cnt = 16'h0000;
      next_q.mac_cnt = 16'h0000;
      next_q.rdy = 1'b0;
      next_q.pd = 1'b0;
      next_q.phy_rn = 1'b0;
      next_q.mac_rn = 1'b0;
      next_q.pwr = 1'b1;
      next_q.osc = 1'b1;
      next_q.dclk = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    q <= next_q;
  end

  assign system_ready_flag = q.rdy;
  assign powerdown_state_flag = q.pd;
  assign phy_busy = q.phy_cnt != 16'h0000;
  assign mac_busy = q.mac_cnt != 16'h0000;
  assign phy_subsystem_reset_n = q.phy_rn;
  assign mac_interface_reset_n = q.mac_rn;
  assign core_power_enable = q.pwr;
  assign boot_oscillator_clock_enable = q.osc;
  assign diagnostics_clock_gate = q.dclk;

endmodule : spc_sequencer

// file: testbench/spc_mdio_host.sv
// Management host model: drives clause 45 frames on mdc and the shared data line.
// Assumes the device samples on mdc rising edges and the data line has a pull-up.
`timescale 1ns/1ps
module spc_mdio_host (
  // system
  input wire logic clk,
  // device side of the line
  input wire logic mdio_out,
  input wire logic mdio_oe,
  // pins seen by the device
  output logic mdc,
  output logic mdio_in
);
  logic h_en;
  logic h_val;
  // wired line: device first, then host, else the pull-up
  assign mdio_in = mdio_oe ? mdio_out : (h_en ? h_val : 1'b1);
  initial begin
    mdc = 1'b0;
    h_en = 1'b0;
    h_val = 1'b1;
  end
  // one frame: preamble, start, opcode, port, device, turnaround, data
  task automatic xfer(input logic [1:0] op, input logic [4:0] prt, input logic [4:0] dev,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hffffffff, 2'h0, op, prt, dev, 2'h2, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      @(negedge clk);
      mdc = 1'b0;
      h_en = !(op[1] && i < 18); // reads hand turnaround and data to the device
      h_val = bits[i];
      repeat (5) @(negedge clk);
      mdc = 1'b1;
      if (i < 16) begin
        rd[i] = mdio_in;
      end
      repeat (4) @(negedge clk);
    end
    @(negedge clk);
    mdc = 1'b0; // clock stands still between frames
    h_en = 1'b0;
  endtask : xfer
endmodule : spc_mdio_host

// file: testbench/spc_power_reset_control_properties.sv
// Assertions on the ports of the power and reset control top.
// Assumes one clock domain; bound to every instance of the top module.
`timescale 1ns/1ps
module spc_checker #(
  parameter int STARTUP_CYCLES = spc_pkg::SPC_STARTUP_CYCLES,
  parameter int RESET_CYCLES = spc_pkg::SPC_RESET_CYCLES
) (
  // system
  input wire logic clk,
  input wire logic rst_n,
  // management pins
  input wire logic mdio_out,
  input wire logic mdio_oe,
  // controlled outputs and status
  input wire logic phy_subsystem_reset_n,
  input wire logic mac_interface_reset_n,
  input wire logic core_power_enable,
  input wire logic boot_oscillator_clock_enable,
  input wire logic diagnostics_clock_gate,
  input wire logic system_ready,
  input wire logic powerdown_state
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  int run;
  int boot;
  // cycles spent booting since reset release or power-down exit
  always_ff @(posedge clk) begin
    if (!rst_n || system_ready || powerdown_state) begin
      boot <= 0;
    end else begin
      boot <= boot + 1;
    end
  end
  // length of a managed subsystem reset pulse while running
  always_ff @(posedge clk) begin
    if (!rst_n || phy_subsystem_reset_n || !system_ready) begin
      run <= 0;
    end else begin
      run <= run + 1;
    end
  end
  chk_pd_core_off: assert property (powerdown_state && $past(powerdown_state) |->
    !core_power_enable && !system_ready && !diagnostics_clock_gate) else $error("pd core on");
  chk_run_osc_on: assert property (!powerdown_state && !$past(powerdown_state) |->
    boot_oscillator_clock_enable) else $error("osc off while running");
  chk_reset_len: assert property (run <= RESET_CYCLES) else $error("reset pulse long");
  chk_reset_needs_ready: assert property (phy_subsystem_reset_n || mac_interface_reset_n
    |-> system_ready || $past(system_ready)) else $error("reset released not ready");
  chk_ready_rise: assert property ($rose(system_ready) |->
    !powerdown_state && core_power_enable) else $error("ready in pd");
  chk_ta_zero: assert property ($rose(mdio_oe) |-> !mdio_out)
    else $error("turnaround not 0");
  chk_oe_holds: assert property ($rose(mdio_oe) |-> mdio_oe [*8])
    else $error("read drive short");
  chk_release_quiet: assert property ($rose(rst_n) |->
    !system_ready && !powerdown_state && !mdio_oe) else $error("status after reset");
  chk_pd_enter: assert property ($rose(powerdown_state) |=> !system_ready)
    else $error("ready kept in pd");
  chk_ready_time: assert property ($rose(system_ready) |-> boot == STARTUP_CYCLES)
    else $error("start-up length wrong");
endmodule : spc_checker

bind spc_power_reset_control spc_checker #(.STARTUP_CYCLES(STARTUP_CYCLES),
  .RESET_CYCLES(RESET_CYCLES)) u_chk (.clk(clk), .rst_n(rst_n), .mdio_out(mdio_out),
  .mdio_oe(mdio_oe), .phy_subsystem_reset_n(phy_subsystem_reset_n),
  .mac_interface_reset_n(mac_interface_reset_n), .core_power_enable(core_power_enable),
  .boot_oscillator_clock_enable(boot_oscillator_clock_enable),
  .diagnostics_clock_gate(diagnostics_clock_gate), .system_ready(system_ready),
  .powerdown_state(powerdown_state));

// file: testbench/spc_power_reset_control_tb_top.sv
// Self-checking bench for the power and reset control top, with a host model on the pins.
// Assumes shortened counts; stimulus moves on falling clock edges.
`timescale 1ns/1ps
module spc_power_reset_control_tb_top;
  localparam int STARTUP = 8;
  localparam int RSTC = 3;
  logic clk, rst_n, mdc, mdio_in, mdio_out, mdio_oe, strap;
  logic phy_rn, mac_rn, core_en, osc_en, diag_g, ready, pd_state;
  logic [4:0] port;
  logic [5:0] pkg;
  logic [3:0] st;
  logic [15:0] rd;
  int bad_count;
  int n_compared;
  int run [2];
  int last_run [2];

  spc_power_reset_control #(.STARTUP_CYCLES(STARTUP), .RESET_CYCLES(RSTC)) u_dut (
    .clk(clk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .port_address(port), .powerdown_strap_pin(strap),
    .package_type_pins(pkg), .phy_subsystem_reset_n(phy_rn), .mac_interface_reset_n(mac_rn),
    .core_power_enable(core_en), .boot_oscillator_clock_enable(osc_en),
    .diagnostics_clock_gate(diag_g), .system_ready(ready), .powerdown_state(pd_state));
  spc_mdio_host u_host (.clk(clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc),
    .mdio_in(mdio_in));

  assign st = {mac_rn, phy_rn, pd_state, ready};

  // clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // length of each managed reset pulse seen while running
  always @(posedge clk) begin
    for (int k = 0; k < 2; k++) begin
      if (!st[2 + k] && ready) begin
        run[k] <= run[k] + 1;
      end else begin
        if (run[k] != 0) begin
          last_run[k] <= run[k];
        end
        run[k] <= 0;
      end
    end
  end

  task automatic end_of_test;
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  // address frame then write frame
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [4:0] p);
    u_host.xfer(2'h0, p, 5'h1e, a, rd);
    u_host.xfer(2'h1, p, 5'h1e, d, rd);
  endtask : wr

  // address frame then read frame, result compared
  task automatic rdc(input logic [15:0] a, input logic [4:0] p, input logic [15:0] exp);
    u_host.xfer(2'h0, p, 5'h1e, a, rd);
    u_host.xfer(2'h3, p, 5'h1e, 16'h0000, rd);
    check(rd, exp);
  endtask : rdc

  // bounded wait for one status output; running out ends the run
  task automatic wait_bit(input int idx, input logic v, input int lim);
    int n;
    n = 0;
    while (st[idx] !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    check({15'h0000, st[idx]}, {15'h0000, v});
    if (st[idx] !== v) begin
      end_of_test();
    end
  endtask : wait_bit

  task automatic do_reset(input logic s);
    strap = s;
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
  endtask : do_reset

  // reset values, read-only places and an unmapped address
  task automatic t_reset_values;
    logic [15:0] addr [9];
    logic [15:0] exp [9];
    addr = '{16'h8812, 16'h8814, 16'h8815, 16'h8818, 16'h8819, 16'h882c, 16'h8c22,
             16'h8c30, 16'h8813};
    exp = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0002, 16'h002a,
            16'h0000, 16'h0000};
    do_reset(1'b0);
    check({14'h0000, pd_state, ready}, 16'h0000);
    wait_bit(0, 1'b1, STARTUP + 20);
    check({13'h0000, core_en, osc_en, diag_g}, 16'h0006);
    for (int i = 0; i < 9; i++) begin
      rdc(addr[i], port, exp[i]);
    end
    wr(16'h8818, 16'hffff, port);
    wr(16'h8c22, 16'hffff, port);
    rdc(16'h8818, port, 16'h0001);
    rdc(16'h8c22, port, 16'h002a);
  endtask : t_reset_values

  // control bits reach their outputs; reserved bits stay as reset
  task automatic t_rw;
    wr(16'h8819, 16'hffff, port);
    wr(16'h882c, 16'hffff, port);
    rdc(16'h8819, port, 16'h0001);
    rdc(16'h882c, port, 16'h0003);
    check({14'h0000, osc_en, diag_g}, 16'h0003);
    // read with post-increment steps the pointer onto the next register
    u_host.xfer(2'h0, port, 5'h1e, 16'h882b, rd);
    u_host.xfer(2'h2, port, 5'h1e, 16'h0000, rd);
    check(rd, 16'h0000);
    u_host.xfer(2'h3, port, 5'h1e, 16'h0000, rd);
    check(rd, 16'h0003);
  endtask : t_rw

  // each managed reset pulses its output and the bit clears by itself
  task automatic t_trigger;
    for (int k = 0; k < 2; k++) begin
      wr(16'h8814 + 16'(k), 16'h0001, port);
      rdc(16'h8814 + 16'(k), port, 16'h0000);
      check(16'(last_run[k]), 16'(RSTC));
    end
  endtask : t_trigger

  // power-down with the oscillator forced, access kept, then wake-up
  task automatic t_powerdown;
    wr(16'h8812, 16'h0001, port);
    wait_bit(1, 1'b1, 200);
    check({12'h000, ready, core_en, osc_en, diag_g}, 16'h0002);
    rdc(16'h8818, port, 16'h0002);
    rdc(16'h8812, port, 16'h0001);
    wr(16'h8819, 16'h0000, port);
    rdc(16'h8819, port, 16'h0000);
    check({15'h0000, osc_en}, 16'h0000);
    wr(16'h8812, 16'h0000, port);
    wait_bit(0, 1'b1, STARTUP + 50);
    check({13'h0000, pd_state, osc_en, diag_g}, 16'h0003);
  endtask : t_powerdown

  // foreign device address ignored; group port takes writes, never reads
  task automatic t_group;
    u_host.xfer(2'h0, port, 5'h01, 16'h8819, rd);
    u_host.xfer(2'h1, port, 5'h01, 16'h0001, rd);
    rdc(16'h8819, port, 16'h0000);
    wr(16'h8c30, 16'h0001, port);
    wr(16'h8819, 16'h0001, 5'h1f);
    rdc(16'h8819, port, 16'h0001);
    rdc(16'h8819, 5'h1f, 16'hffff);
    rdc(16'h8c30, port, 16'h0001);
    wr(16'h8c30, 16'h0000, port);
    wr(16'h8819, 16'h0000, 5'h1f);
    rdc(16'h8819, port, 16'h0001);
  endtask : t_group

  // strap high: second reset in mid-run lands in power-down
  task automatic t_strap;
    do_reset(1'b1);
    wait_bit(1, 1'b1, 20);
    rdc(16'h8812, port, 16'h0001);
    rdc(16'h8818, port, 16'h0002);
  endtask : t_strap

  // main sequence
  initial begin
    rst_n = 1'b0;
    strap = 1'b0;
    port = 5'h03;
    pkg = 6'h2a;
    bad_count = 0;
    n_compared = 0;
    t_reset_values();
    t_rw();
    t_trigger();
    t_powerdown();
    t_group();
    t_strap();
    end_of_test();
  end
endmodule : spc_power_reset_control_tb_top
